// ==== hw/uife_pkg.sv ====
// uife_pkg: offsets, fields and carriers of the usb irq enable/flag block
`default_nettype none
package uife_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFF_EN_A  = 8'h00;
  localparam logic [7:0] OFF_EN_B  = 8'h04;
  localparam logic [7:0] OFF_FLG_A = 8'h08;
  localparam logic [7:0] OFF_ROUTE = 8'h0C;
  localparam logic [7:0] OFF_CTRL  = 8'h10;
  // -------------------------------------------------------------------
  // reset values and writable masks
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] MASK_EN_A  = 8'h7F;
  localparam logic [7:0] MASK_EN_B  = 8'h03;
  localparam logic [7:0] MASK_ROUTE = 8'h03;
  localparam logic [4:0] MASK_STICKY = 5'h1F;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int EN_SETUP  = 0;
  localparam int EN_OK     = 1;
  localparam int EN_FAIL   = 2;
  localparam int EN_SUSP   = 3;
  localparam int EN_SOF    = 4;
  localparam int EN_BRST   = 5;
  localparam int EN_FIFO   = 6;
  localparam int EN_INTF   = 0;
  localparam int EN_CONFIG = 1;
  localparam int FL_SETUP  = 0;
  localparam int FL_SUSPIN = 1;
  localparam int FL_SUSPOUT = 2;
  localparam int FL_SOF    = 3;
  localparam int FL_BRST   = 4;
  localparam int FL_FIFO   = 5;
  localparam int FL_FAIL   = 6;
  localparam int FL_OK     = 7;
  localparam int RT_LINE_B = 0;
  localparam int RT_LINE_C = 1;
  localparam int CT_SWRST  = 0;
  // -------------------------------------------------------------------
  // bus answers
  // -------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // events and levels from the usb function core (same clock)
  typedef struct packed {
    logic [7:0] ep_xfer_ok_flags;
    logic [7:0] ep_xfer_fail_flags;
    logic       fifo_read_req;
    logic       set_config_det;
    logic       set_intf_det;
    logic       setup_evt;
    logic       bus_reset_evt;
    logic       frame_start_evt;
    logic       suspend_out_evt;
    logic       suspend_in_evt;
  } uife_core_s;
  // four request lines toward the slave cpu
  typedef struct packed {
    logic irq_line_setup;
    logic irq_line_xfer_one;
    logic irq_line_xfer_two;
    logic irq_line_misc;
  } uife_irq_s;
endpackage : uife_pkg
`default_nettype wire

// ==== hw/uife_top.sv ====
// uife_top: usb function irq enable, flag and request line logic
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
// Overview of operation
// - both enable registers clear on system or function software reset.
// - flag bits 4:0 clear on system or function software reset; bits 7:5 follow the core.
// - reserved enable bits read zero and ignore writes.
// - enable a bit 6 gates the fifo read request interrupt.
// - enable a bit 5 gates the bus reset interrupt.
// - enable a bit 4 gates the frame start interrupt.
// - enable a bit 3 gates both suspend exit and entry interrupts.
// - enable a bit 2 gates the abnormal completion interrupt.
// - enable a bit 1 gates the normal completion interrupt.
// - enable a bit 0 gates the setup interrupt.
// - enable b bit 1 gates the set configuration detect interrupt.
// - enable b bit 0 gates the set interface detect interrupt.
// - exactly four interrupt request outputs go to the slave cpu.
// - first request line carries only the setup interrupt.
// - second and third lines each route normal or abnormal completion.
// - fourth line carries every other event source.
// - flag bit 7 is the or of endpoint normal completion flags.
// - enabled normal completion summary asserts the fourth line.
// - flag bit 6 reports abnormal end of an endpoint transfer.
// - enabled abnormal completion summary asserts the fourth line.
// - bus reset flag sets on event, clears by zero after read one.
module uife_top
  import uife_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  // usb function core sources
  input  wire uife_core_s  core,
  // request lines
  output var  uife_irq_s   irq
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [7:0] en_a_q, en_b_q, route_q;
  logic [4:0] sticky_q, armed_q;
  logic [4:0] ev, clr;
  logic       swrst_q;
  logic       aw_got_q, w_got_q;
  logic [7:0] aw_addr_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;
  logic [7:0] flag_a;
  logic       clr_all;
  logic       do_wr;
  logic       rd_take;
  logic       ts_sum, tf_sum;
  uife_irq_s  irq_d;

  // register index decode, shared by both bus paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_EN_A) || (a == OFF_EN_B) || (a == OFF_FLG_A) ||
             (a == OFF_ROUTE) || (a == OFF_CTRL);
  endfunction

  // -------------------------------------------------------------------
  // summary flags and flag register view
  // -------------------------------------------------------------------
  // or of endpoint flags
  assign ts_sum = |core.ep_xfer_ok_flags;
  assign tf_sum = |core.ep_xfer_fail_flags;
  // summaries follow the endpoint registers, no state of their own
  assign flag_a = {ts_sum, tf_sum, core.fifo_read_req, sticky_q};
  assign clr_all = !aresetn || swrst_q;
  assign do_wr   = aw_got_q && w_got_q && !bvalid;
  assign rd_take = arvalid && arready;

  // -------------------------------------------------------------------
  // write channel
  // -------------------------------------------------------------------
  // address and data taken in either order, held until both arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_addr_q <= 8'h00;
      wbyte_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q  <= 1'b1;
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q  <= 1'b1;
        wready   <= 1'b0;
        wbyte_q  <= wdata[7:0];
        wstrb0_q <= wstrb[0];
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid   <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        awready  <= 1'b1;
        wready   <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------------
  // one read in flight; data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFF_EN_A:  rdata <= {24'h000000, en_a_q & MASK_EN_A};
        OFF_EN_B:  rdata <= {24'h000000, en_b_q & MASK_EN_B};
        OFF_FLG_A: rdata <= {24'h000000, flag_a};
        OFF_ROUTE: rdata <= {24'h000000, route_q};
        default:   rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // enable registers
  // -------------------------------------------------------------------
  // clear on either reset
  always_ff @(posedge aclk) begin
    if (clr_all) begin
      en_a_q <= RST_BYTE;
      en_b_q <= RST_BYTE;
    end else if (do_wr && wstrb0_q) begin
      if (aw_addr_q == OFF_EN_A)
        en_a_q <= wbyte_q & MASK_EN_A;
      if (aw_addr_q == OFF_EN_B)
        en_b_q <= wbyte_q & MASK_EN_B;
    end
  end

  // route and control sit outside the function reset on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= RST_BYTE;
      swrst_q <= 1'b0;
    end else begin
      swrst_q <= 1'b0;
      if (do_wr && wstrb0_q && aw_addr_q == OFF_ROUTE)
        route_q <= wbyte_q & MASK_ROUTE;
      if (do_wr && wstrb0_q && aw_addr_q == OFF_CTRL)
        swrst_q <= wbyte_q[CT_SWRST];
    end
  end

  // -------------------------------------------------------------------
  // sticky flags
  // -------------------------------------------------------------------
  // events in flag order; a clear needs a 0 bit and a read that saw 1
  always_comb begin
    ev  = '0;
    clr = '0;
    ev[FL_SETUP]   = core.setup_evt;
    ev[FL_SUSPIN]  = core.suspend_in_evt;
    ev[FL_SUSPOUT] = core.suspend_out_evt;
    ev[FL_SOF]     = core.frame_start_evt;
    ev[FL_BRST]    = core.bus_reset_evt;
    if (do_wr && wstrb0_q && aw_addr_q == OFF_FLG_A)
      clr = ~wbyte_q[4:0] & armed_q & MASK_STICKY;
  end

  // clear only after a read saw one; a new event wins the clear
  always_ff @(posedge aclk) begin
    if (clr_all) begin
      sticky_q <= 5'h00;
      armed_q  <= 5'h00;
    end else begin
      sticky_q <= (sticky_q & ~clr) | ev;
      armed_q  <= (armed_q & ~clr & ~ev) |
                  ((rd_take && araddr == OFF_FLG_A) ? sticky_q : 5'h00);
    end
  end

  // -------------------------------------------------------------------
  // request lines
  // -------------------------------------------------------------------
  always_comb begin
    logic ok_en, fail_en, misc;
    ok_en   = ts_sum && en_a_q[EN_OK];
    fail_en = tf_sum && en_a_q[EN_FAIL];
    misc    = ok_en || fail_en;
    irq_d.irq_line_setup = sticky_q[FL_SETUP] && en_a_q[EN_SETUP];
    irq_d.irq_line_xfer_one = route_q[RT_LINE_B] ? fail_en : ok_en;
    irq_d.irq_line_xfer_two = route_q[RT_LINE_C] ? fail_en : ok_en;
    misc = misc || (core.fifo_read_req && en_a_q[EN_FIFO]);
    misc = misc || (sticky_q[FL_BRST] && en_a_q[EN_BRST]);
    misc = misc || (sticky_q[FL_SOF] && en_a_q[EN_SOF]);
    // one bit for both suspend flags
    misc = misc || ((sticky_q[FL_SUSPOUT] || sticky_q[FL_SUSPIN]) &&
                    en_a_q[EN_SUSP]);
    misc = misc || (core.set_config_det && en_b_q[EN_CONFIG]);
    misc = misc || (core.set_intf_det && en_b_q[EN_INTF]);
    irq_d.irq_line_misc = misc;
  end

  // four registered lines, held as levels
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= '0;
    else
      irq <= irq_d;
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  en_reset_a:
  assert property (@(posedge aclk) swrst_q |=> en_a_q == 8'h00 &&
                   en_b_q == 8'h00)
    else $error("enables not cleared by function reset");
  flag_reset_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   swrst_q |=> sticky_q == 5'h00)
    else $error("flags not cleared by function reset");
  rsvd_zero_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   en_a_q[7] == 1'b0 && en_b_q[7:2] == 6'h00)
    else $error("reserved enable bit set");
  setup_line_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   ##1 irq.irq_line_setup ==
                   $past(sticky_q[FL_SETUP] && en_a_q[EN_SETUP]))
    else $error("setup line not following its flag");
  ok_misc_a:
  assert property (@(posedge aclk) disable iff (!aresetn || swrst_q)
                   (ts_sum && en_a_q[EN_OK]) |=> irq.irq_line_misc)
    else $error("normal completion missing on misc line");
  fail_misc_a:
  assert property (@(posedge aclk) disable iff (!aresetn || swrst_q)
                   (tf_sum && en_a_q[EN_FAIL]) |=> irq.irq_line_misc)
    else $error("abnormal completion missing on misc line");
  brst_set_a:
  assert property (@(posedge aclk) disable iff (!aresetn || swrst_q)
                   core.bus_reset_evt |=> sticky_q[FL_BRST])
    else $error("bus reset event lost");
  brst_keep_a:
  assert property (@(posedge aclk) disable iff (!aresetn || swrst_q)
                   (sticky_q[FL_BRST] && !armed_q[FL_BRST])
                   |=> sticky_q[FL_BRST])
    else $error("bus reset flag cleared without prior read");
  susp_gate_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   (!en_a_q[EN_SUSP] && !en_a_q[EN_SOF] &&
                    !en_a_q[EN_BRST] && !en_a_q[EN_FIFO] &&
                    !en_a_q[EN_OK] && !en_a_q[EN_FAIL] &&
                    en_b_q == 8'h00) |=> !irq.irq_line_misc)
    else $error("misc line raised with all enables off");
  route_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   (route_q[RT_LINE_B] && en_a_q[EN_FAIL] && tf_sum)
                   |=> irq.irq_line_xfer_one)
    else $error("line b not following abnormal route");
  wr_resp_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   do_wr |=> bvalid)
    else $error("write response not raised");
  en_sysrst_a:
  assert property (@(posedge aclk) !aresetn |=> en_a_q == RST_BYTE &&
                   en_b_q == RST_BYTE)
    else $error("enables not cleared by system reset");
  flag_sysrst_a:
  assert property (@(posedge aclk) !aresetn |=> sticky_q == 5'h00 &&
                   armed_q == 5'h00)
    else $error("flags not cleared by system reset");
  route_two_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   (route_q[RT_LINE_C] && en_a_q[EN_FAIL] && tf_sum)
                   |=> irq.irq_line_xfer_two)
    else $error("line c not following abnormal route");
  fifo_misc_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   (core.fifo_read_req && en_a_q[EN_FIFO])
                   |=> irq.irq_line_misc)
    else $error("fifo read request missing on misc line");
  susp_misc_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
                   (sticky_q[FL_SUSPIN] && en_a_q[EN_SUSP])
                   |=> irq.irq_line_misc)
    else $error("suspend entry missing on misc line");

endmodule : uife_top
`default_nettype wire

// ==== verification/uife_core_model.sv ====
// uife_core_model: usb function core stand-in, events and levels
`default_nettype none
module uife_core_model
  import uife_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // bench requests
  input  wire logic [4:0] ev_req,
  input  wire logic [4:0] lv_req,
  // toward the block
  output var  uife_core_s core
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] req_q;
  // bus reset and other events
  // edge detect: a held request still gives a one-cycle pulse
  always_ff @(posedge aclk) begin
    req_q <= ev_req;
    {core.setup_evt, core.bus_reset_evt, core.frame_start_evt,
     core.suspend_out_evt, core.suspend_in_evt} <= ev_req & ~req_q;
    // levels share the process so one process owns the whole struct
    // outermost endpoints to catch a narrowed or
    core.ep_xfer_ok_flags   <= {lv_req[0], 7'h00};
    core.ep_xfer_fail_flags <= {7'h00, lv_req[1]};
    core.fifo_read_req      <= lv_req[2];
    core.set_config_det     <= lv_req[3];
    core.set_intf_det       <= lv_req[4];
  end
endmodule // uife_core_model
`default_nettype wire

// ==== verification/uife_top_tb.sv ====
// uife_top_tb: register and request line tests for the irq block
`default_nettype none
module uife_top_tb
  import uife_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, resp;
  logic [4:0]  ev_req = 5'h00, lv_req = 5'h00;
  uife_core_s  core;
  uife_irq_s   irq;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0;
  // 50 MHz clock
  always #10 aclk = ~aclk;
  uife_top i_uife_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .core, .irq);
  uife_core_model i_uife_core_model (.aclk, .ev_req, .lv_req, .core);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_t = 1'b0;
    bit w_t = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (!aw_t && awready) begin
        awvalid <= 1'b0;
        aw_t = 1'b1;
      end
      if (!w_t && wready) begin
        wvalid <= 1'b0;
        w_t = 1'b1;
      end
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    check(rd_d, e);
  endtask
  task automatic pulse(input int i);
    ev_req[i] <= 1'b1;
    @(posedge aclk);
    ev_req <= 5'h00;
    repeat (4) @(posedge aclk);
  endtask
  // one source: flag seen, line held off, enabled, then cleared
  task automatic run_src(input bit lvl, input int i, input logic [7:0] a,
                         input logic [7:0] en, input logic [7:0] fm,
                         input logic [3:0] ie);
    if (lvl) begin
      lv_req[i] <= 1'b1;
      repeat (5) @(posedge aclk);
    end else
      pulse(i);
    rd_chk(OFF_FLG_A, {24'h0, fm});
    check({28'h0, irq}, 32'h0);
    axi_wr(a, {24'h0, en});
    repeat (3) @(posedge aclk);
    check({28'h0, irq}, {28'h0, ie});
    if (lvl)
      lv_req[i] <= 1'b0;
    else
      axi_wr(OFF_FLG_A, 32'h0);
    repeat (4) @(posedge aclk);
    check({28'h0, irq}, 32'h0);
    axi_wr(a, 32'h0);
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFF_EN_A, 32'h0);
    rd_chk(OFF_EN_B, 32'h0);
    rd_chk(OFF_FLG_A, 32'h0);
    check($bits(irq), 32'd4);
    axi_wr(OFF_EN_A, 32'hFF);
    check(32'(resp), 32'(RESP_OKAY));
    rd_chk(OFF_EN_A, 32'h7F);
    check(32'(resp), 32'(RESP_OKAY));
    axi_wr(OFF_EN_B, 32'hFF);
    rd_chk(OFF_EN_B, 32'h03);
    axi_wr(OFF_EN_A, 32'h0);
    axi_wr(OFF_EN_B, 32'h0);
    // a write without the low byte strobe leaves the register alone
    wstrb <= 4'hE;
    axi_wr(OFF_EN_A, 32'h7F);
    wstrb <= 4'hF;
    rd_chk(OFF_EN_A, 32'h0);
    // unmapped place answers with an error and zero data
    axi_wr(8'h14, 32'hFF);
    check(32'(resp), 32'(RESP_SLVERR));
    axi_rd(8'h14);
    check(rd_d, 32'h0);
    check(32'(resp), 32'(RESP_SLVERR));
    // every source against its enable bit and line
    run_src(0, 4, OFF_EN_A, 8'h01, 8'h01, 4'h8);
    run_src(0, 3, OFF_EN_A, 8'h20, 8'h10, 4'h1);
    run_src(0, 2, OFF_EN_A, 8'h10, 8'h08, 4'h1);
    run_src(0, 1, OFF_EN_A, 8'h08, 8'h04, 4'h1);
    run_src(0, 0, OFF_EN_A, 8'h08, 8'h02, 4'h1);
    run_src(1, 0, OFF_EN_A, 8'h02, 8'h80, 4'h7);
    run_src(1, 1, OFF_EN_A, 8'h04, 8'h40, 4'h1);
    run_src(1, 2, OFF_EN_A, 8'h40, 8'h20, 4'h1);
    run_src(1, 3, OFF_EN_B, 8'h02, 8'h00, 4'h1);
    run_src(1, 4, OFF_EN_B, 8'h01, 8'h00, 4'h1);
    // a clear without a prior read must not take effect
    pulse(3);
    axi_wr(OFF_FLG_A, 32'h0);
    rd_chk(OFF_FLG_A, 32'h10);
    axi_wr(OFF_FLG_A, 32'hFF);
    rd_chk(OFF_FLG_A, 32'h10);
    axi_wr(OFF_FLG_A, 32'h0);
    rd_chk(OFF_FLG_A, 32'h0);
    // line one takes abnormal, line two normal completion
    axi_wr(OFF_ROUTE, 32'h1);
    axi_wr(OFF_EN_A, 32'h04);
    lv_req <= 5'h02;
    pulse(4);
    check({28'h0, irq}, 32'h5);
    // both stand together: the routed line and the fourth line
    check(32'(irq.irq_line_xfer_one && irq.irq_line_misc), 32'h1);
    // line two takes abnormal, line one normal completion
    axi_wr(OFF_ROUTE, 32'h2);
    repeat (3) @(posedge aclk);
    check({28'h0, irq}, 32'h3);
    // function software reset keeps routing and live flag bits, drops enables and sticky flags
    axi_wr(OFF_EN_B, 32'h3);
    axi_wr(OFF_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    check({28'h0, irq}, 32'h0);
    rd_chk(OFF_EN_A, 32'h0);
    rd_chk(OFF_FLG_A, 32'h40);
    rd_chk(OFF_EN_B, 32'h0);
    rd_chk(OFF_ROUTE, 32'h2);
    lv_req <= 5'h00;
    // second system reset in mid-run
    axi_wr(OFF_EN_B, 32'h3);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFF_EN_B, 32'h0);
    summarize();
  end
endmodule // uife_top_tb
`default_nettype wire
